// ### rtl/occ_clkout_div.sv
/*
 * clock output divider: square wave at source rate over 2, 4 or 10; divisor 1 holds the output high.
 * assumes: core_clk stands for the source clock; run low stops output.
 */
`timescale 1ns/1ps
`include "occ_regs.svh"

module occ_clkout_div (
	input wire logic core_clk,
	input wire logic arst_n,
	input wire logic run,
	input wire logic [1:0] clkout_divisor,
	output logic clock_out_pin
);
	import occ_pkg::*;

	logic [3:0] cnt_reg;
	logic [3:0] div_reg;
	logic [3:0] div_sel;
	logic period_end;

	// ----------------------------------------------------------------
	// divisor decode
	// ----------------------------------------------------------------
	assign div_sel = (clkout_divisor == 2'h3) ? `OCC_DIV_BY10 :
		(clkout_divisor == 2'h2) ? `OCC_DIV_BY4 :
		(clkout_divisor == 2'h1) ? `OCC_DIV_BY2 : `OCC_DIV_BY1;
	assign period_end = (cnt_reg == div_reg - 4'h1);

	// ----------------------------------------------------------------
	// counter; new divisor taken at a period end or while run is low
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			cnt_reg <= 4'h0;
			div_reg <= `OCC_DIV_BY10;
			clock_out_pin <= 1'b0;
		end else if (!run) begin
			cnt_reg <= 4'h0;
			div_reg <= div_sel;
			clock_out_pin <= 1'b0;
		end else if (period_end) begin
			cnt_reg <= 4'h0;
			div_reg <= div_sel;
			clock_out_pin <= 1'b1;
		end else begin
			cnt_reg <= cnt_reg + 4'h1;
			clock_out_pin <= ((cnt_reg + 4'h1) < ((div_reg + 4'h1) >> 1));
		end
	end

endmodule : occ_clkout_div

// ### rtl/occ_pkg.sv
/*
 * types of the oscillator and clock control block.
 * assumes: compiled before every module of the block.
 */
package occ_pkg;

	// ----------------------------------------------------------------
	// writable control fields
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [1:0] clkout_divisor;
		logic sysclk_halve;
		logic deep_sleep_select;
		logic osc_disable;
		logic pll_source_select;
	} occ_ctrl_t;

	// ----------------------------------------------------------------
	// status flags
	// ----------------------------------------------------------------
	typedef struct packed {
		logic sysclk_div_synced;
		logic osc_stable_flag;
		logic pll_lock_flag;
	} occ_stat_t;

	// ----------------------------------------------------------------
	// register access from the serial engine
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [11:0] addr;
		logic [3:0] be;
		logic wr;
		logic rd;
		logic [31:0] wdata;
	} occ_acc_t;

	// ----------------------------------------------------------------
	// asynchronous pins
	// ----------------------------------------------------------------
	typedef struct packed {
		logic osc_running;
		logic pll_locked;
		logic can_receive_pin;
		logic host_select_n;
	} occ_pins_t;

	typedef enum logic [1:0] {st_run, st_sleep, st_deep} occ_state_t;

endpackage : occ_pkg

// ### rtl/occ_regs.svh
/*
 * offsets, field positions, reset values and timing counts of the
 * oscillator and clock control block.
 * assumes: included by bare name; no process or assignment here.
 */
`ifndef OCC_REGS_SVH
`define OCC_REGS_SVH

// ----------------------------------------------------------------
// register address
// ----------------------------------------------------------------
`define OCC_OSC_ADDR 12'h000

// ----------------------------------------------------------------
// field positions of the oscillator control register
// ----------------------------------------------------------------
`define OCC_PLL_SEL_BIT 0
`define OCC_OSC_DIS_BIT 2
`define OCC_DEEP_SEL_BIT 3
`define OCC_HALVE_BIT 4
`define OCC_CLOCK_OUT_PIN_LSB 5
`define OCC_CLOCK_OUT_PIN_MSB 6
`define OCC_PLL_RDY_BIT 8
`define OCC_OSC_RDY_BIT 10
`define OCC_DIV_SYNC_BIT 12

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define OCC_CLOCK_OUT_PIN_RST 2'h3
`define OCC_PIN_IDLE 4'h3

// ----------------------------------------------------------------
// clock output divisors
// ----------------------------------------------------------------
`define OCC_DIV_BY10 4'ha
`define OCC_DIV_BY4 4'h4
`define OCC_DIV_BY2 4'h2
`define OCC_DIV_BY1 4'h1

// ----------------------------------------------------------------
// mode request and timing
// ----------------------------------------------------------------
`define OCC_REQ_SLEEP 3'h1
`define OCC_CORE_CLK_MHZ 40
`define OCC_SWITCH_NS 1000
`define OCC_SWITCH_CYC ((`OCC_SWITCH_NS * `OCC_CORE_CLK_MHZ + 999) / 1000)

`endif

// ### rtl/occ_top.sv
/*
 * oscillator and clock control: control register, source switch,
 * system clock halving, clock output, sleep and deep power-down.
 * assumes: core_clk is the always-on reference; register accesses come
 * from the serial engine on core_clk; pins arrive asynchronously.
 */
`timescale 1ns/1ps
`include "occ_regs.svh"

module occ_top (
	input wire logic core_clk,
	input wire logic arst_n,
	input wire occ_pkg::occ_acc_t acc,
	output logic [31:0] rdata,
	output logic rvalid,
	input wire logic config_mode,
	input wire logic [2:0] opmode_request,
	input wire logic bus_wake_irq_enable,
	input wire occ_pkg::occ_pins_t pins,
	output logic osc_enable,
	output logic pll_enable,
	output logic sysclk_sel_pll,
	output logic sysclk_en,
	output logic clock_out_pin,
	output logic sleep_active,
	output logic deep_power_down,
	output logic wake_to_config
);
	import occ_pkg::*;

	localparam logic [7:0] SWITCH_CYC = 8'(`OCC_SWITCH_CYC);
	localparam logic [3:0] PIN_IDLE = `OCC_PIN_IDLE;

	// ----------------------------------------------------------------
	// pin synchronisers
	// ----------------------------------------------------------------
	logic [3:0] pin_raw;
	logic [3:0] s1_reg;
	logic [3:0] s2_reg;
	logic [3:0] s3_reg;
	logic [3:0] flt_reg;
	occ_pins_t pin_f;

	assign pin_raw = pins;
	assign pin_f = flt_reg;

	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_sync
			always_ff @(posedge core_clk or negedge arst_n) begin
				if (!arst_n) begin
					s1_reg[gi] <= PIN_IDLE[gi];
					s2_reg[gi] <= PIN_IDLE[gi];
					s3_reg[gi] <= PIN_IDLE[gi];
					flt_reg[gi] <= PIN_IDLE[gi];
				end else begin
					s1_reg[gi] <= pin_raw[gi];
					s2_reg[gi] <= s1_reg[gi];
					s3_reg[gi] <= s2_reg[gi];
					if (s2_reg[gi] == s3_reg[gi]) begin
						flt_reg[gi] <= s3_reg[gi];
					end
				end
			end
		end
	endgenerate

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	occ_state_t state_reg;
	occ_state_t state_next;
	occ_ctrl_t ctrl_reg;
	occ_ctrl_t ctrl_next;
	occ_ctrl_t ctrl_rst;
	occ_stat_t stat_reg;
	logic req_d_reg;
	logic rx_d_reg;
	logic cs_d_reg;
	logic [7:0] sw_cnt_reg;
	logic half_reg;
	logic phase_reg;

	// ----------------------------------------------------------------
	// access decode
	// ----------------------------------------------------------------
	logic hit;
	logic wr_lane0;
	logic cfg_wr;
	logic [7:0] wbyte;
	logic [31:0] rd_word;

	assign hit = (acc.addr[11:2] == `OCC_OSC_ADDR >> 2);
	assign wr_lane0 = acc.wr & hit & acc.be[0] & (state_reg != st_deep);
	assign cfg_wr = wr_lane0 & config_mode;
	assign wbyte = acc.wdata[7:0];
	assign ctrl_rst = '{clkout_divisor: `OCC_CLOCK_OUT_PIN_RST, default: 1'b0};

	// ----------------------------------------------------------------
	// sleep request and wake events
	// ----------------------------------------------------------------
	logic req_sleep;
	logic sleep_edge;
	logic rx_fall;
	logic cs_fall;
	logic wake_rx;
	logic clr_wake;
	logic wake_sleep;
	logic wake_deep;

	assign req_sleep = (opmode_request == `OCC_REQ_SLEEP);
	assign sleep_edge = req_sleep & ~req_d_reg & (state_reg == st_run);
	assign rx_fall = rx_d_reg & ~pin_f.can_receive_pin;
	assign cs_fall = cs_d_reg & ~pin_f.host_select_n;
	assign wake_rx = rx_fall & bus_wake_irq_enable;
	assign clr_wake = wr_lane0 & ~wbyte[`OCC_OSC_DIS_BIT];
	assign wake_sleep = (state_reg == st_sleep) & (clr_wake | wake_rx);
	assign wake_deep = (state_reg == st_deep) & (cs_fall | wake_rx);

	always_comb begin
		state_next = state_reg;
		case (state_reg)
			st_run: begin
				if (sleep_edge) begin
					state_next = ctrl_reg.deep_sleep_select ? st_deep : st_sleep;
				end
			end
			st_sleep: begin
				if (wake_sleep) begin
					state_next = st_run;
				end
			end
			st_deep: begin
				if (wake_deep) begin
					state_next = st_run;
				end
			end
			default: state_next = st_run;
		endcase
	end

	// ----------------------------------------------------------------
	// control fields
	// ----------------------------------------------------------------
	always_comb begin
		ctrl_next = ctrl_reg;
		if (wr_lane0) begin
			ctrl_next.clkout_divisor = wbyte[`OCC_CLOCK_OUT_PIN_MSB:`OCC_CLOCK_OUT_PIN_LSB];
			ctrl_next.deep_sleep_select = wbyte[`OCC_DEEP_SEL_BIT];
			if (!wbyte[`OCC_OSC_DIS_BIT]) begin
				ctrl_next.osc_disable = 1'b0;
			end
		end
		if (cfg_wr) begin
			ctrl_next.sysclk_halve = wbyte[`OCC_HALVE_BIT];
			ctrl_next.pll_source_select = wbyte[`OCC_PLL_SEL_BIT];
		end
		if (wake_sleep) begin
			ctrl_next.osc_disable = 1'b0;
		end
		if (sleep_edge) begin
			ctrl_next.osc_disable = 1'b1;
		end
		if (wake_deep) begin
			ctrl_next = ctrl_rst;
		end
	end

	// ----------------------------------------------------------------
	// source switch
	// ----------------------------------------------------------------
	logic want_pll;
	logic mismatch;
	logic busy;
	logic osc_ok;
	logic pll_ok;
	logic src_ok;
	logic run_clk;
	logic half_apply;

	assign want_pll = ctrl_reg.pll_source_select;
	assign mismatch = (sysclk_sel_pll != want_pll);
	assign busy = mismatch | (sw_cnt_reg != 8'h0);
	assign osc_ok = pin_f.osc_running & osc_enable;
	assign pll_ok = pin_f.pll_locked & pll_enable;
	assign src_ok = osc_ok & (~sysclk_sel_pll | pll_ok);
	assign run_clk = src_ok & ~busy;
	assign half_apply = ~half_reg | phase_reg | ~run_clk;

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			sw_cnt_reg <= 8'h0;
			sysclk_sel_pll <= 1'b0;
		end else if (sw_cnt_reg != 8'h0) begin
			sw_cnt_reg <= sw_cnt_reg - 8'h1;
			if (sw_cnt_reg == 8'h1) begin
				sysclk_sel_pll <= want_pll;
			end
		end else if (mismatch & (~want_pll | pll_ok)) begin
			sw_cnt_reg <= SWITCH_CYC;
		end
	end

	// ----------------------------------------------------------------
	// system clock halving
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			half_reg <= 1'b0;
			phase_reg <= 1'b0;
			sysclk_en <= 1'b0;
		end else begin
			if (half_apply) begin
				half_reg <= ctrl_reg.sysclk_halve;
			end
			phase_reg <= (half_apply | ~run_clk) ? 1'b0 : ~phase_reg;
			sysclk_en <= run_clk & (~half_reg | phase_reg);
		end
	end

	// ----------------------------------------------------------------
	// main registers
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			state_reg <= st_run;
			ctrl_reg <= '{clkout_divisor: `OCC_CLOCK_OUT_PIN_RST, default: 1'b0};
			stat_reg <= '0;
			req_d_reg <= 1'b0;
			rx_d_reg <= 1'b1;
			cs_d_reg <= 1'b1;
			osc_enable <= 1'b0;
			pll_enable <= 1'b0;
			sleep_active <= 1'b0;
			deep_power_down <= 1'b0;
			wake_to_config <= 1'b0;
		end else begin
			state_reg <= state_next;
			ctrl_reg <= ctrl_next;
			req_d_reg <= req_sleep;
			rx_d_reg <= pin_f.can_receive_pin;
			cs_d_reg <= pin_f.host_select_n;
			osc_enable <= (state_next == st_run) & ~ctrl_next.osc_disable;
			pll_enable <= (state_next == st_run) &
				(ctrl_next.pll_source_select | sysclk_sel_pll);
			sleep_active <= (state_next != st_run);
			deep_power_down <= (state_next == st_deep);
			wake_to_config <= wake_sleep | wake_deep;
			stat_reg.sysclk_div_synced <= half_reg;
			stat_reg.osc_stable_flag <= run_clk;
			stat_reg.pll_lock_flag <= pll_ok;
		end
	end

	// ----------------------------------------------------------------
	// clock output
	// ----------------------------------------------------------------
	occ_clkout_div u_clkout (
		.core_clk(core_clk),
		.arst_n(arst_n),
		.run(run_clk),
		.clkout_divisor(ctrl_reg.clkout_divisor),
		.clock_out_pin(clock_out_pin)
	);

	// ----------------------------------------------------------------
	// read back
	// ----------------------------------------------------------------
	always_comb begin
		rd_word = 32'h0;
		rd_word[`OCC_PLL_SEL_BIT] = ctrl_reg.pll_source_select;
		rd_word[`OCC_OSC_DIS_BIT] = ctrl_reg.osc_disable;
		rd_word[`OCC_DEEP_SEL_BIT] = ctrl_reg.deep_sleep_select;
		rd_word[`OCC_HALVE_BIT] = ctrl_reg.sysclk_halve;
		rd_word[`OCC_CLOCK_OUT_PIN_MSB:`OCC_CLOCK_OUT_PIN_LSB] = ctrl_reg.clkout_divisor;
		rd_word[`OCC_PLL_RDY_BIT] = stat_reg.pll_lock_flag;
		rd_word[`OCC_OSC_RDY_BIT] = stat_reg.osc_stable_flag;
		rd_word[`OCC_DIV_SYNC_BIT] = stat_reg.sysclk_div_synced;
	end

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			rdata <= 32'h0;
			rvalid <= 1'b0;
		end else begin
			rdata <= (acc.rd & hit) ? rd_word : 32'h0;
			rvalid <= acc.rd;
		end
	end

endmodule : occ_top

// ### tb/occ_top_props.sv
/*
 * concurrent checks on the ports of the clock control top.
 * assumes: bound to occ_top; one clock, async active-low reset.
 */
`timescale 1ns/1ps

module occ_top_props (
	input wire logic core_clk,
	input wire logic arst_n,
	input wire occ_pkg::occ_acc_t acc,
	input wire logic [31:0] rdata,
	input wire logic rvalid,
	input wire logic [2:0] opmode_request,
	input wire logic osc_enable,
	input wire logic pll_enable,
	input wire logic sysclk_sel_pll,
	input wire logic sysclk_en,
	input wire logic sleep_active,
	input wire logic deep_power_down,
	input wire logic wake_to_config
);
	import occ_pkg::*;
	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!arst_n);
	property p_rd_answer; acc.rd |=> rvalid; endproperty
	a_rd_answer: assert property (p_rd_answer) else $error("read not answered");
	property p_idle_zero; !rvalid |-> rdata == 32'h0; endproperty
	a_idle_zero: assert property (p_idle_zero) else $error("read data without read");
	property p_unimpl; rvalid |-> (rdata & 32'hffffea82) == 32'h0; endproperty
	a_unimpl: assert property (p_unimpl) else $error("unimplemented bit set");
	property p_reserved; rvalid && $past(acc.addr[11:2]) != 10'h0 |-> rdata == 32'h0; endproperty
	a_reserved: assert property (p_reserved) else $error("reserved read not zero");
	property p_sleep_osc; sleep_active |-> !osc_enable; endproperty
	a_sleep_osc: assert property (p_sleep_osc) else $error("oscillator on in sleep");
	property p_sleep_clk; sleep_active ##1 sleep_active |-> !sysclk_en; endproperty
	a_sleep_clk: assert property (p_sleep_clk) else $error("clock runs in sleep");
	property p_deep; deep_power_down |-> sleep_active; endproperty
	a_deep: assert property (p_deep) else $error("deep without sleep");
	property p_entry; $rose(sleep_active) |-> $past(opmode_request) == 3'h1; endproperty
	a_entry: assert property (p_entry) else $error("sleep without request");
	property p_wake; wake_to_config |-> !sleep_active && $past(sleep_active); endproperty
	a_wake: assert property (p_wake) else $error("wake pulse out of place");
	property p_wake_len; wake_to_config |=> !wake_to_config; endproperty
	a_wake_len: assert property (p_wake_len) else $error("wake pulse too long");
	property p_pll_on; sysclk_sel_pll && !sleep_active |-> pll_enable; endproperty
	a_pll_on: assert property (p_pll_on) else $error("pll selected unpowered");
endmodule : occ_top_props

bind occ_top occ_top_props u_props (.core_clk(core_clk), .arst_n(arst_n), .acc(acc),
	.rdata(rdata), .rvalid(rvalid), .opmode_request(opmode_request), .osc_enable(osc_enable),
	.pll_enable(pll_enable), .sysclk_sel_pll(sysclk_sel_pll), .sysclk_en(sysclk_en),
	.sleep_active(sleep_active), .deep_power_down(deep_power_down),
	.wake_to_config(wake_to_config));

// ### tb/tb_oscillator_clock_control.sv
/*
 * self-checking bench of the clock control top, one task a scenario.
 * assumes: design and checker compiled before; 40 MHz core clock.
 */
`timescale 1ns/1ps
`include "occ_regs.svh"

module tb_oscillator_clock_control;
	import occ_pkg::*;
	logic core_clk, arst_n, rvalid, config_mode, bus_wake_irq_enable;
	logic osc_enable, pll_enable, sysclk_sel_pll, sysclk_en, clock_out_pin;
	logic sleep_active, deep_power_down, wake_to_config;
	logic [31:0] rdata;
	logic [2:0] opmode_request;
	occ_acc_t acc;
	occ_pins_t pins;
	int n_mismatch, cmp_count;
	occ_top dut (.core_clk(core_clk), .arst_n(arst_n), .acc(acc), .rdata(rdata),
		.rvalid(rvalid), .config_mode(config_mode), .opmode_request(opmode_request),
		.bus_wake_irq_enable(bus_wake_irq_enable), .pins(pins), .osc_enable(osc_enable),
		.pll_enable(pll_enable), .sysclk_sel_pll(sysclk_sel_pll), .sysclk_en(sysclk_en),
		.clock_out_pin(clock_out_pin), .sleep_active(sleep_active),
		.deep_power_down(deep_power_down), .wake_to_config(wake_to_config));
	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	initial begin
		core_clk = 1'b0;
		forever #12.5 core_clk = ~core_clk;
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic step(input int n);
		repeat (n) @(posedge core_clk);
		#2;
	endtask : step
	task automatic wr(input logic [31:0] d, input logic [3:0] be);
		step(1);
		acc.addr = `OCC_OSC_ADDR;
		acc.wdata = d;
		acc.be = be;
		acc.wr = 1'b1;
		step(1);
		acc.wr = 1'b0;
	endtask : wr
	task automatic rd(input logic [11:0] a, output logic [31:0] d);
		int i;
		step(1);
		acc.addr = a;
		acc.rd = 1'b1;
		step(1);
		acc.rd = 1'b0;
		for (i = 0; i < 3 && rvalid !== 1'b1; i++) step(1);
		d = (rvalid === 1'b1) ? rdata : 32'hxxxxxxxx;
	endtask : rd
	task automatic wait_wake(output logic seen);
		int i;
		seen = (wake_to_config === 1'b1);
		for (i = 0; i < 12 && !seen; i++) begin
			step(1);
			seen = (wake_to_config === 1'b1);
		end
	endtask : wait_wake
	task automatic count_en(output int c);
		c = 0;
		repeat (20) begin
			step(1);
			c += (sysclk_en === 1'b1);
		end
	endtask : count_en
	task automatic wrap_up();
		$display("compares %0d mismatches %0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask : wrap_up
	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic t_refuse();
		logic [31:0] d;
		rd(`OCC_OSC_ADDR, d);
		chk(d, 32'h460);
		config_mode = 1'b0;
		wr(32'hffffffff, 4'hf);
		rd(`OCC_OSC_ADDR, d);
		chk(d, 32'h468);
		chk(sleep_active, 1'b0);
		wr(32'h0, 4'he);
		rd(`OCC_OSC_ADDR, d);
		chk(d, 32'h468);
		rd(12'h004, d);
		chk(d, 32'h0);
		wr(32'h60, 4'h1);
	endtask : t_refuse
	task automatic t_clkout();
		int per[4] = '{1, 2, 4, 10};
		int n, rises, highs;
		logic prev;
		for (n = 0; n < 4; n++) begin
			wr({25'h0, n[1:0], 5'h0}, 4'h1);
			step(20);
			prev = clock_out_pin;
			rises = 0;
			highs = 0;
			repeat (40) begin
				step(1);
				rises += (clock_out_pin === 1'b1 && prev === 1'b0);
				highs += (clock_out_pin === 1'b1);
				prev = clock_out_pin;
			end
			chk(rises, per[n] == 1 ? 0 : 40 / per[n]);
			chk(highs, 40 * ((per[n] + 1) / 2) / per[n]);
		end
	endtask : t_clkout
	task automatic t_halve();
		logic [31:0] d;
		int c;
		config_mode = 1'b1;
		wr(32'h70, 4'h1);
		step(10);
		count_en(c);
		chk(c, 10);
		rd(`OCC_OSC_ADDR, d);
		chk(d & 32'hfffffbff, 32'h1070);
		wr(32'h60, 4'h1);
		step(10);
		count_en(c);
		chk(c, 20);
		rd(`OCC_OSC_ADDR, d);
		chk(d & 32'hfffffbff, 32'h60);
	endtask : t_halve
	task automatic t_pll();
		logic [31:0] d;
		int i;
		pins.pll_locked = 1'b1;
		step(10);
		wr(32'h61, 4'h1);
		step(3);
		chk(sysclk_en, 1'b0);
		rd(`OCC_OSC_ADDR, d);
		chk(d[10], 1'b0);
		for (i = 0; i < 80 && sysclk_sel_pll !== 1'b1; i++) step(1);
		chk(sysclk_sel_pll, 1'b1);
		step(5);
		rd(`OCC_OSC_ADDR, d);
		chk(d, 32'h561);
		config_mode = 1'b0;
		wr(32'h60, 4'h1);
		step(60);
		chk(sysclk_sel_pll, 1'b1);
		config_mode = 1'b1;
		wr(32'h60, 4'h1);
		chk(pll_enable, 1'b1);
		for (i = 0; i < 80 && sysclk_sel_pll !== 1'b0; i++) step(1);
		chk(sysclk_sel_pll, 1'b0);
		step(5);
		chk(pll_enable, 1'b0);
	endtask : t_pll
	task automatic t_sleep();
		logic [31:0] d;
		logic seen;
		opmode_request = `OCC_REQ_SLEEP;
		step(3);
		chk({sleep_active, deep_power_down, osc_enable}, 3'b100);
		rd(`OCC_OSC_ADDR, d);
		chk(d & 32'h7d, 32'h64);
		pins.can_receive_pin = 1'b0;
		wait_wake(seen);
		pins.can_receive_pin = 1'b1;
		chk({seen, sleep_active}, 2'b01);
		opmode_request = 3'h0;
		wr(32'h60, 4'h1);
		wait_wake(seen);
		chk({seen, sleep_active}, 2'b10);
		rd(`OCC_OSC_ADDR, d);
		chk(d & 32'h7d, 32'h60);
		bus_wake_irq_enable = 1'b1;
		opmode_request = `OCC_REQ_SLEEP;
		step(3);
		opmode_request = 3'h0;
		pins.can_receive_pin = 1'b0;
		wait_wake(seen);
		pins.can_receive_pin = 1'b1;
		chk({seen, sleep_active}, 2'b10);
	endtask : t_sleep
	task automatic t_deep();
		logic [31:0] d;
		logic seen;
		wr(32'h68, 4'h1);
		step(3);
		chk(sleep_active, 1'b0);
		opmode_request = `OCC_REQ_SLEEP;
		step(3);
		opmode_request = 3'h0;
		chk({sleep_active, deep_power_down}, 2'b11);
		wr(32'h0, 4'h1);
		step(3);
		chk(deep_power_down, 1'b1);
		pins.host_select_n = 1'b0;
		wait_wake(seen);
		pins.host_select_n = 1'b1;
		chk({seen, sleep_active}, 2'b10);
		step(10);
		rd(`OCC_OSC_ADDR, d);
		chk(d & 32'h7d, 32'h60);
	endtask : t_deep
	// ----------------------------------------------------------------
	// main sequence and timeout
	// ----------------------------------------------------------------
	initial begin
		int cyc;
		cyc = 0;
		forever begin
			@(posedge core_clk);
			cyc++;
			if (cyc == 6000) begin
				n_mismatch++;
				wrap_up();
			end
		end
	end
	initial begin
		n_mismatch = 0;
		cmp_count = 0;
		arst_n = 1'b0;
		acc = '0;
		config_mode = 1'b0;
		opmode_request = 3'h0;
		bus_wake_irq_enable = 1'b0;
		pins = '{osc_running: 1'b1, pll_locked: 1'b0, can_receive_pin: 1'b1, host_select_n: 1'b1};
		step(12);
		arst_n = 1'b1;
		step(10);
		t_refuse();
		t_clkout();
		t_halve();
		t_pll();
		t_sleep();
		t_deep();
		wrap_up();
	end
endmodule : tb_oscillator_clock_control
